// ===== src/flash_cfg_core.sv
// Serial-pin front end and volatile protocol configuration register
`timescale 1ns/1ps

module flash_cfg_core (
    input  wire logic                    clock,
    input  wire logic                    nrst,
    input  wire logic                    sclk,
    input  wire logic                    cs_n,
    input  wire logic [3:0]              dq_in,
    output logic      [3:0]              dq_out,
    output logic      [3:0]              dq_oe_n,
    input  wire logic [3:0]              dummy_cycles,
    output flash_cfg_pkg::settings_t     active,
    output logic      [7:0]              cfg_value
);

    // ----------------------------------------------------------------
    // Pin capture
    // ----------------------------------------------------------------
    flash_cfg_pkg::pins_t raw;
    flash_cfg_pkg::pins_t p;

    assign raw = '{sclk: sclk, cs_n: cs_n, dq: dq_in};

    pin_sync3 #(
        .W   (6),
        .RST (flash_cfg_pkg::PINS_IDLE)
    ) u_sync (
        .clock (clock),
        .nrst  (nrst),
        .din   (raw),
        .dout  (p)
    );

    // ----------------------------------------------------------------
    // Frame engine
    // ----------------------------------------------------------------
    flash_cfg_pkg::core_t q;
    flash_cfg_pkg::core_t d;

    logic       rise;
    logic       fall;
    logic       edge_hit;
    logic       cs_start;
    logic       frame_end;
    logic       hold_abort;
    logic       rescue_hit;
    logic [3:0] lanes;
    logic [3:0] in_bits;
    logic [7:0] sh_next;
    logic [3:0] cnt_next;
    logic [3:0] dummy_eff;
    logic [7:0] readback;
    logic [7:0] out_next;

    always_comb
    begin
        lanes      = flash_cfg_pkg::lane_count(q.act.proto);
        in_bits    = flash_cfg_pkg::lane_in(p.dq, q.act.proto);
        rise       = p.sclk & ~q.sclk_prev;
        fall       = ~p.sclk & q.sclk_prev;
        edge_hit   = rise | (fall & q.act.dtr);
        cs_start   = q.cs_prev & ~p.cs_n;
        frame_end  = ~q.cs_prev & p.cs_n;
        // Four-line mode uses data line three for data, so hold/reset is off there
        hold_abort = q.act.hold_reset_en && (q.act.proto != flash_cfg_pkg::PROTO_QUAD)
                     && !p.dq[3] && !p.cs_n;
        rescue_hit = q.rescue_ok && (q.rescue_cnt >= flash_cfg_pkg::RESCUE_EDGES);
        sh_next    = (q.sh_in << lanes) | {4'h0, in_bits};
        cnt_next   = q.cnt + lanes;
        dummy_eff  = (dummy_cycles == flash_cfg_pkg::DUMMY_ALIAS_LO ||
                      dummy_cycles == flash_cfg_pkg::DUMMY_ALIAS_HI)
                     ? flash_cfg_pkg::DUMMY_DEFAULT : dummy_cycles;
        readback   = q.cfg | flash_cfg_pkg::RSVD_MASK;
        out_next   = q.sh_out << lanes;
        if (cnt_next == flash_cfg_pkg::BYTE_BITS)
        begin
            out_next = q.rd_pat ? flash_cfg_pkg::CAL_PATTERN : readback;
        end
    end

    always_comb
    begin
        d = q;
        d.sclk_prev = p.sclk;
        d.cs_prev   = p.cs_n;

        // Rescue: a whole frame with data line 0 held high for enough clocks
        if (rise && !p.cs_n)
        begin
            d.rescue_ok = q.rescue_ok & p.dq[0];
            if (q.rescue_cnt != flash_cfg_pkg::RESCUE_EDGES)
            begin
                d.rescue_cnt = q.rescue_cnt + 5'h1;
            end
        end

        if (cs_start)
        begin
            d.st         = flash_cfg_pkg::ST_CMD;
            d.cnt        = 4'h0;
            d.sh_in      = 8'h00;
            d.wr_pend    = 1'b0;
            d.rd_cfg     = 1'b0;
            d.rescue_cnt = 5'h00;
            d.rescue_ok  = 1'b1;
        end
        else if (p.cs_n)
        begin
            d.st      = flash_cfg_pkg::ST_IDLE;
            d.dq_oe_n = 4'hf;
            d.wr_pend = 1'b0;
            d.rd_cfg  = 1'b0;
            if (frame_end)
            begin
                if (rescue_hit)
                begin
                    d.cfg = flash_cfg_pkg::CFG_DEFAULT;
                    d.act = flash_cfg_pkg::SETTINGS_DEFAULT;
                end
                else if (q.wr_pend)
                begin
                    // Switch only at frame end so the rest of this frame keeps its protocol
                    d.cfg = q.wr_val | flash_cfg_pkg::RSVD_MASK;
                    d.act = flash_cfg_pkg::decode_cfg(q.wr_val);
                end
                else if (q.rd_cfg)
                begin
                    d.act = flash_cfg_pkg::decode_cfg(q.cfg);
                end
            end
        end
        else if (hold_abort)
        begin
            d.st      = flash_cfg_pkg::ST_IDLE;
            d.dq_oe_n = 4'hf;
            d.wr_pend = 1'b0;
            d.rd_cfg  = 1'b0;
        end
        else if (edge_hit)
        begin
            case (q.st)
                flash_cfg_pkg::ST_CMD:
                begin
                    d.sh_in = sh_next;
                    d.cnt   = cnt_next;
                    if (cnt_next == flash_cfg_pkg::BYTE_BITS)
                    begin
                        d.cnt = 4'h0;
                        case (sh_next)
                            flash_cfg_pkg::OP_WRITE_CFG:
                            begin
                                d.st = flash_cfg_pkg::ST_WDATA;
                            end
                            flash_cfg_pkg::OP_READ_CFG:
                            begin
                                d.st      = flash_cfg_pkg::ST_RDATA;
                                d.rd_cfg  = 1'b1;
                                d.rd_pat  = 1'b0;
                                d.sh_out  = readback;
                                d.dq_o    = flash_cfg_pkg::lane_out(readback, q.act.proto);
                                d.dq_oe_n = flash_cfg_pkg::oe_mask(q.act.proto);
                            end
                            flash_cfg_pkg::OP_CAL_PATTERN:
                            begin
                                d.st     = flash_cfg_pkg::ST_DUMMY;
                                d.dummy  = dummy_eff;
                                d.rd_pat = 1'b1;
                            end
                            default:
                            begin
                                d.st = flash_cfg_pkg::ST_IGNORE;
                            end
                        endcase
                    end
                end
                flash_cfg_pkg::ST_WDATA:
                begin
                    d.sh_in = sh_next;
                    d.cnt   = cnt_next;
                    if (cnt_next == flash_cfg_pkg::BYTE_BITS)
                    begin
                        d.cnt     = 4'h0;
                        d.wr_val  = sh_next;
                        d.wr_pend = 1'b1;
                        d.st      = flash_cfg_pkg::ST_IGNORE;
                    end
                end
                flash_cfg_pkg::ST_DUMMY:
                begin
                    if (rise)
                    begin
                        if (q.dummy == 4'h1)
                        begin
                            d.st      = flash_cfg_pkg::ST_RDATA;
                            d.cnt     = 4'h0;
                            d.sh_out  = flash_cfg_pkg::CAL_PATTERN;
                            d.dq_o    = flash_cfg_pkg::lane_out(flash_cfg_pkg::CAL_PATTERN,
                                                                q.act.proto);
                            d.dq_oe_n = flash_cfg_pkg::oe_mask(q.act.proto);
                        end
                        else
                        begin
                            d.dummy = q.dummy - 4'h1;
                        end
                    end
                end
                flash_cfg_pkg::ST_RDATA:
                begin
                    // Update after the edge the host samples on; the sync delay gives hold
                    d.cnt    = (cnt_next == flash_cfg_pkg::BYTE_BITS) ? 4'h0 : cnt_next;
                    d.sh_out = out_next;
                    d.dq_o   = flash_cfg_pkg::lane_out(out_next, q.act.proto);
                end
                default:
                begin
                    d.st = q.st;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            q <= flash_cfg_pkg::CORE_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign dq_out    = q.dq_o;
    assign dq_oe_n   = q.dq_oe_n;
    assign active    = q.act;
    assign cfg_value = q.cfg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    sequence dummy_entry_s;
        q.st == flash_cfg_pkg::ST_CMD ##1 q.st == flash_cfg_pkg::ST_DUMMY;
    endsequence

    sequence dummy_last_s;
        q.st == flash_cfg_pkg::ST_DUMMY && q.dummy == 4'h1 && rise && !p.cs_n && !hold_abort;
    endsequence

    quad_select_a: assert property (!q.cfg[7] |-> q.act.proto == flash_cfg_pkg::PROTO_QUAD)
        else $error("quad enable low but quad protocol not active");
    dual_select_a: assert property (q.cfg[7] && !q.cfg[6]
                                    |-> q.act.proto == flash_cfg_pkg::PROTO_DUAL)
        else $error("dual enable low alone but dual protocol not active");
    rate_select_a: assert property (q.act.dtr == !q.cfg[5] && q.act.drive == q.cfg[2:0])
        else $error("rate or drive setting disagrees with register");
    write_switch_a: assert property (frame_end && q.wr_pend && !rescue_hit
                                     |=> q.cfg == ($past(q.wr_val) | flash_cfg_pkg::RSVD_MASK)
                                         && q.act == flash_cfg_pkg::decode_cfg($past(q.wr_val)))
        else $error("written value not applied at end of write frame");
    rescue_default_a: assert property (frame_end && rescue_hit
                                       |=> q.cfg == flash_cfg_pkg::CFG_DEFAULT
                                           && q.act.proto == flash_cfg_pkg::PROTO_EXT)
        else $error("rescue sequence did not restore defaults");
    reset_default_a: assert property ($rose(nrst) |-> q.cfg == 8'hff && !q.act.dtr)
        else $error("configuration not default after reset");
    reserved_bit_a: assert property ($rose(q.st == flash_cfg_pkg::ST_RDATA) && !q.rd_pat
                                     |-> q.sh_out[3])
        else $error("reserved bit read back as zero");
    read_download_a: assert property (frame_end && q.rd_cfg && !q.wr_pend && !rescue_hit
                                      |=> q.act == flash_cfg_pkg::decode_cfg(q.cfg))
        else $error("read command did not download settings");
    dummy_load_a: assert property (dummy_entry_s |-> q.dummy == $past(dummy_eff))
        else $error("dummy count not loaded from companion field");
    pattern_out_a: assert property (dummy_last_s |=> q.st == flash_cfg_pkg::ST_RDATA
                                                     && q.sh_out == flash_cfg_pkg::CAL_PATTERN)
        else $error("calibration pattern not presented after dummy cycles");
    hold_abort_a: assert property (hold_abort && !cs_start |=> q.st == flash_cfg_pkg::ST_IDLE
                                                               && q.dq_oe_n == 4'hf)
        else $error("hold/reset on data line three did not end the frame");

endmodule : flash_cfg_core

// ===== include/flash_cfg_pkg.sv
// Shared constants, types and helpers for the volatile protocol configuration block
package flash_cfg_pkg;

    // ----------------------------------------------------------------
    // Register layout
    // ----------------------------------------------------------------
    localparam logic [7:0] CFG_DEFAULT  = 8'hff;
    localparam int         QUAD_EN_BIT  = 7;
    localparam int         DUAL_EN_BIT  = 6;
    localparam int         RATE_SEL_BIT = 5;
    localparam int         HOLD_EN_BIT  = 4;
    localparam int         DRV_MSB      = 2;
    localparam logic [7:0] RSVD_MASK    = 8'h08;

    localparam logic [2:0] DRV_90       = 3'h1;
    localparam logic [2:0] DRV_45       = 3'h3;
    localparam logic [2:0] DRV_20       = 3'h5;
    localparam logic [2:0] DRV_30       = 3'h7;

    // ----------------------------------------------------------------
    // Commands, calibration pattern and timing counts
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_CFG   = 8'h61;
    localparam logic [7:0] OP_READ_CFG    = 8'h65;
    localparam logic [7:0] OP_CAL_PATTERN = 8'h41;
    localparam logic [7:0] CAL_PATTERN    = 8'h35;
    localparam logic [3:0] DUMMY_DEFAULT  = 4'ha;
    localparam logic [3:0] DUMMY_ALIAS_LO = 4'h0;
    localparam logic [3:0] DUMMY_ALIAS_HI = 4'hf;
    localparam logic [4:0] RESCUE_EDGES   = 5'h10;
    localparam logic [3:0] BYTE_BITS      = 4'h8;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PROTO_EXT  = 2'b00,
        PROTO_DUAL = 2'b01,
        PROTO_QUAD = 2'b10
    } proto_t;

    typedef struct packed {
        proto_t     proto;
        logic       dtr;
        logic       hold_reset_en;
        logic [2:0] drive;
    } settings_t;

    localparam settings_t SETTINGS_DEFAULT = '{proto: PROTO_EXT, dtr: 1'b0,
                                               hold_reset_en: 1'b1, drive: DRV_30};

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_CMD    = 3'b001,
        ST_WDATA  = 3'b010,
        ST_DUMMY  = 3'b011,
        ST_RDATA  = 3'b100,
        ST_IGNORE = 3'b101
    } frame_st_t;

    typedef struct packed {
        logic       sclk;
        logic       cs_n;
        logic [3:0] dq;
    } pins_t;

    localparam pins_t PINS_IDLE = '{sclk: 1'b0, cs_n: 1'b1, dq: 4'hf};

    typedef struct packed {
        frame_st_t  st;
        logic       sclk_prev;
        logic       cs_prev;
        logic [7:0] sh_in;
        logic [3:0] cnt;
        logic [7:0] sh_out;
        logic       rd_pat;
        logic       rd_cfg;
        logic [3:0] dummy;
        logic       wr_pend;
        logic [7:0] wr_val;
        logic [4:0] rescue_cnt;
        logic       rescue_ok;
        logic [7:0] cfg;
        settings_t  act;
        logic [3:0] dq_o;
        logic [3:0] dq_oe_n;
    } core_t;

    localparam core_t CORE_RESET = '{st: ST_IDLE, cs_prev: 1'b1, cfg: CFG_DEFAULT,
                                     act: SETTINGS_DEFAULT, dq_oe_n: 4'hf, default: '0};

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic settings_t decode_cfg(input logic [7:0] c);
        settings_t s;
        s.proto = !c[QUAD_EN_BIT] ? PROTO_QUAD : (!c[DUAL_EN_BIT] ? PROTO_DUAL : PROTO_EXT);
        s.dtr = !c[RATE_SEL_BIT];
        s.hold_reset_en = c[HOLD_EN_BIT];
        s.drive = c[DRV_MSB:0];
        return s;
    endfunction : decode_cfg

    function automatic logic [3:0] lane_count(input proto_t p);
        case (p)
            PROTO_DUAL: return 4'h2;
            PROTO_QUAD: return 4'h4;
            default:    return 4'h1;
        endcase
    endfunction : lane_count

    function automatic logic [3:0] lane_in(input logic [3:0] dq, input proto_t p);
        case (p)
            PROTO_DUAL: return {2'h0, dq[1:0]};
            PROTO_QUAD: return dq;
            default:    return {3'h0, dq[0]};
        endcase
    endfunction : lane_in

    // Single-line reads leave on data line 1, wider modes use the low lines
    function automatic logic [3:0] lane_out(input logic [7:0] sh, input proto_t p);
        case (p)
            PROTO_DUAL: return {2'h0, sh[7:6]};
            PROTO_QUAD: return sh[7:4];
            default:    return {2'h0, sh[7], 1'b0};
        endcase
    endfunction : lane_out

    function automatic logic [3:0] oe_mask(input proto_t p);
        case (p)
            PROTO_DUAL: return 4'hc;
            PROTO_QUAD: return 4'h0;
            default:    return 4'hd;
        endcase
    endfunction : oe_mask

endpackage : flash_cfg_pkg

// ===== src/pin_sync3.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps

module pin_sync3 #(
    parameter int             W   = 1,
    parameter logic [W-1:0]   RST = '0
) (
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] stable;
    } sync_t;

    sync_t q;
    sync_t d;

    always_comb
    begin
        d = q;
        d.s1 = din;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < W; i++)
        begin
            if (q.s2[i] == q.s3[i])
            begin
                d.stable[i] = q.s3[i];
            end
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            q <= '{s1: RST, s2: RST, s3: RST, stable: RST};
        end
        else
        begin
            q <= d;
        end
    end

    assign dout = q.stable;

endmodule : pin_sync3

// ===== sim/host_model.sv
// Host-side serial bus controller model that drives the link pins
`timescale 1ns/1ps

module host_model (
    input  wire logic       clock,
    input  wire logic [3:0] dq_wire,
    output logic            sclk,
    output logic            cs_n,
    output logic [3:0]      dq_drv,
    output logic            dq_en
);
    // 400 ns serial clock: far below every frequency ceiling, so any dummy count works
    localparam int HALF = 4;

    logic hold_n;

    initial
    begin
        sclk   = 1'b0;
        cs_n   = 1'b1;
        dq_drv = 4'hf;
        dq_en  = 1'b0;
        hold_n = 1'b1;
    end

    task automatic half_wait();
        repeat (HALF) @(negedge clock);
    endtask : half_wait

    task automatic start();
        @(negedge clock);
        cs_n = 1'b0;
        half_wait();
    endtask : start

    task automatic stop();
        half_wait();
        cs_n  = 1'b1;
        dq_en = 1'b0;
        repeat (2 * HALF) @(negedge clock);
    endtask : stop

    // Whole byte, MSB first, lanes bits per edge; below four lanes data line 3 carries hold_n
    task automatic xfer(input logic [7:0] tx, input int lanes, input bit dtr, input bit rd,
                        output logic [7:0] rx);
        logic [3:0] c;
        logic [3:0] m;
        m = 4'((1 << lanes) - 1);
        rx = 8'h00;
        dq_en = !rd;
        for (int i = 0; i < 8; i += lanes)
        begin
            c = 4'(tx >> (8 - lanes - i)) & m;
            dq_drv = (lanes == 4) ? c : {hold_n, 1'b1, (lanes == 2) ? c[1:0] : {1'b1, c[0]}};
            half_wait();
            rx = (rx << lanes) | 8'((lanes == 1) ? 4'(dq_wire[1]) : (dq_wire & m));
            sclk = dtr ? ~sclk : 1'b1;
            half_wait();
            if (!dtr)
                sclk = 1'b0;
        end
    endtask : xfer

    // Exactly the configured number of dummy edges is clocked before sampling
    task automatic pulses(input int n, input logic [3:0] v);
        dq_en = 1'b1;
        dq_drv = v;
        repeat (n)
        begin
            half_wait();
            sclk = 1'b1;
            half_wait();
            sclk = 1'b0;
        end
    endtask : pulses
endmodule : host_model

// ===== sim/serial_flash_volatile_protocol_config_tb.sv
// Self-checking bench for the volatile protocol configuration block
`timescale 1ns/1ps

module serial_flash_volatile_protocol_config_tb;
    typedef struct packed {
        logic [7:0]               wval;
        logic [7:0]               cfg;
        flash_cfg_pkg::settings_t set;
    } row_t;

    logic                     clock;
    logic                     nrst;
    logic                     sclk;
    logic                     cs_n;
    logic                     dq_en;
    logic [3:0]               dq_drv;
    logic [3:0]               dq_wire;
    logic [3:0]               dq_out;
    logic [3:0]               dq_oe_n;
    logic [3:0]               dummy_cycles;
    logic [7:0]               cfg_value;
    logic [7:0]               rx;
    flash_cfg_pkg::settings_t active;
    int                       failures;
    int                       check_count;
    int                       cycles;
    int                       lanes;
    logic [3:0]               dsel [3] = '{4'h0, 4'h3, 4'hf};
    int                       dexp [3] = '{10, 3, 10};
    // Settings literal is {proto, dtr, hold_reset_en, drive}
    row_t rows [7] = '{'{8'hf7, 8'hff, 7'h0f}, '{8'h7e, 8'h7e, 7'h4e}, '{8'hb1, 8'hb9, 7'h29},
                       '{8'h3b, 8'h3b, 7'h4b}, '{8'hed, 8'hed, 7'h05}, '{8'hf0, 8'hf8, 7'h08},
                       '{8'hff, 8'hff, 7'h0f}};

    // Released lines sit on their pull-ups
    assign dq_wire = (~dq_oe_n & dq_out) | (dq_oe_n & (dq_en ? dq_drv : 4'hf));

    flash_cfg_core flash_cfg_core_i (.clock(clock), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
        .dq_in(dq_wire), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dummy_cycles(dummy_cycles),
        .active(active), .cfg_value(cfg_value));

    host_model host_model_i (.clock(clock), .dq_wire(dq_wire), .sclk(sclk), .cs_n(cs_n),
        .dq_drv(dq_drv), .dq_en(dq_en));

    initial
        clock = 1'b0;
    always #25 clock = ~clock;

    task automatic print_verdict();
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            print_verdict();
        end
    end

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp8

    task automatic cmp_set(input flash_cfg_pkg::settings_t got, input flash_cfg_pkg::settings_t exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_set

    task automatic wr(input logic [7:0] v, input int ln, input bit dtr);
        host_model_i.start();
        host_model_i.xfer(flash_cfg_pkg::OP_WRITE_CFG, ln, dtr, 1'b0, rx);
        host_model_i.xfer(v, ln, dtr, 1'b0, rx);
        host_model_i.stop();
    endtask : wr

    task automatic rd_cfg(input int ln, input logic [7:0] exp);
        host_model_i.start();
        host_model_i.xfer(flash_cfg_pkg::OP_READ_CFG, ln, 1'b0, 1'b0, rx);
        repeat (2) @(negedge clock);
        cmp8({4'h0, dq_oe_n}, (ln == 4) ? 8'h00 : ((ln == 2) ? 8'h0c : 8'h0d));
        host_model_i.xfer(8'h00, ln, 1'b0, 1'b1, rx);
        cmp8(rx, exp);
        host_model_i.stop();
    endtask : rd_cfg

    initial
    begin
        failures = 0;
        check_count = 0;
        cycles = 0;
        nrst = 1'b0;
        dummy_cycles = 4'h0;
        repeat (4) @(negedge clock);
        nrst = 1'b1;
        repeat (4) @(negedge clock);
        cmp8(cfg_value, 8'hff);
        cmp_set(active, 7'h0f);
        lanes = 1;
        for (int r = 0; r < 7; r++)
        begin
            wr(rows[r].wval, lanes, 1'b0);
            cmp8(cfg_value, rows[r].cfg);
            cmp_set(active, rows[r].set);
            lanes = (rows[r].set[6:5] == 2'b10) ? 4 : ((rows[r].set[6:5] == 2'b01) ? 2 : 1);
            rd_cfg(lanes, rows[r].cfg);
        end
        // Double rate, then back to single rate with a double-rate write
        wr(8'hdf, 1, 1'b0);
        cmp_set(active, 7'h1f);
        wr(8'hff, 1, 1'b1);
        cmp_set(active, 7'h0f);
        for (int k = 0; k < 3; k++)
        begin
            dummy_cycles = dsel[k];
            host_model_i.start();
            host_model_i.xfer(flash_cfg_pkg::OP_CAL_PATTERN, 1, 1'b0, 1'b0, rx);
            host_model_i.pulses(dexp[k], 4'hf);
            host_model_i.xfer(8'h00, 1, 1'b0, 1'b1, rx);
            cmp8(rx, flash_cfg_pkg::CAL_PATTERN);
            host_model_i.xfer(8'h00, 1, 1'b0, 1'b1, rx);
            cmp8(rx, flash_cfg_pkg::CAL_PATTERN);
            host_model_i.stop();
        end
        // Write cut short after the command leaves the register alone
        host_model_i.start();
        host_model_i.xfer(flash_cfg_pkg::OP_WRITE_CFG, 1, 1'b0, 1'b0, rx);
        host_model_i.pulses(4, 4'he);
        host_model_i.stop();
        cmp8(cfg_value, 8'hff);
        host_model_i.hold_n = 1'b0;
        wr(8'h7f, 1, 1'b0);
        cmp8(cfg_value, 8'hff);
        host_model_i.hold_n = 1'b1;
        wr(8'hef, 1, 1'b0);
        host_model_i.hold_n = 1'b0;
        wr(8'hff, 1, 1'b0);
        cmp8(cfg_value, 8'hff);
        host_model_i.hold_n = 1'b1;
        wr(8'h7f, 1, 1'b0);
        cmp_set(active, 7'h4f);
        host_model_i.start();
        host_model_i.pulses(16, 4'hf);
        host_model_i.stop();
        cmp8(cfg_value, 8'hff);
        cmp_set(active, 7'h0f);
        // Reset in mid-run drops a quad selection
        wr(8'h7e, 1, 1'b0);
        nrst = 1'b0;
        repeat (2) @(negedge clock);
        cmp8(cfg_value, 8'hff);
        cmp8({4'h0, dq_oe_n}, 8'h0f);
        nrst = 1'b1;
        repeat (4) @(negedge clock);
        cmp_set(active, 7'h0f);
        rd_cfg(1, 8'hff);
        print_verdict();
    end
endmodule : serial_flash_volatile_protocol_config_tb
